// ---- rtl/spd_framer.sv ----
`timescale 1ns/1ps
module spd_framer (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Configuration port
  input  wire spd_pkg::spd_cfg_wr_type cfg_wr,
  input  wire logic [7:0]          cfg_rd_addr,
  output logic [7:0]               cfg_rd_data,
  // Mode inputs
  input  wire logic                rate_fast,
  input  wire logic [7:0]          auto_gap,
  input  wire logic                rts_mode,
  // Host serial byte side
  input  wire logic                host_rx_valid,
  input  wire logic [7:0]          host_rx_data,
  input  wire logic                rts_n,
  output logic                     cts_n,
  output logic                     host_tx_valid,
  output logic [7:0]               host_tx_data,
  input  wire logic                host_tx_ready,
  // Radio side, plus line driver enable, its delay bytes and the inbound count
  output logic                     pkt_valid,
  output spd_pkg::spd_pkt_type     pkt_info,
  input  wire logic                pkt_done,
  input  wire logic                radio_rx_valid,
  input  wire logic [7:0]          radio_rx_data,
  output logic                     line_driver_enable,
  output logic [23:0]              de_delay,
  output logic [15:0]              rx_count
);
  logic [7:0]  de_delay_high, de_delay_middle, de_delay_low;
  logic [7:0]  byte_gap_timeout, packet_size_limit, cfg_flags;
  logic [15:0] flow_stop_threshold, flow_resume_threshold;
  logic [7:0]  next_rd;
  logic [7:0]  next_de_high, next_de_mid, next_de_low, next_gap, next_pkt, next_cfg;
  logic [15:0] next_stop, next_resume;
  logic [7:0]  eff_gap, eff_size, cap;
  spd_pkg::spd_state_type state, next_state;
  logic [7:0]  acc, next_acc;
  logic [7:0]  units, next_units;
  logic [15:0] sub, next_sub;
  logic [15:0] cnt, next_cnt;
  logic        cts_hi, next_cts;
  spd_pkg::spd_pkt_type next_info;
  logic        next_pkt_valid;
  logic [7:0]  otx [spd_pkg::BUF_DEPTH];
  logic [spd_pkg::BUF_AW:0] wp, rp, next_wp, next_rp;
  logic        next_tv;
  logic [7:0]  next_td;
  logic        accept;

  function automatic logic [2:0] slots_of(input logic fast, input logic [7:0] sz);
    // RULE_09 slow-rate slots
    if (!fast) slots_of = (sz <= 8'h09) ? 3'h4 : (sz <= 8'h25) ? 3'h3 : 3'h2;
    // RULE_10 fast-rate slots
    else slots_of = (sz <= 8'h0C) ? 3'h6 : (sz <= 8'h25) ? 3'h5 :
                    (sz <= 8'h47) ? 3'h4 : (sz <= 8'h7D) ? 3'h3 : 3'h2;
  endfunction

  // Configuration write decode
  always_comb begin
    next_de_high = de_delay_high;
    next_de_mid  = de_delay_middle;
    next_de_low  = de_delay_low;
    next_gap     = byte_gap_timeout;
    next_pkt     = packet_size_limit;
    next_cfg     = cfg_flags;
    next_stop    = flow_stop_threshold;
    next_resume  = flow_resume_threshold;
    if (cfg_wr.wr) begin
      case (cfg_wr.addr)
        // RULE_13 delay bytes stored
        spd_pkg::ADR_DE_HIGH: next_de_high = cfg_wr.data;
        spd_pkg::ADR_DE_MID:  next_de_mid  = cfg_wr.data;
        spd_pkg::ADR_DE_LOW:  next_de_low  = cfg_wr.data;
        // RULE_02 minimum two units
        spd_pkg::ADR_GAP:     next_gap = (cfg_wr.data < spd_pkg::GAP_MIN) ?
                                         spd_pkg::GAP_MIN : cfg_wr.data;
        spd_pkg::ADR_PKT:     next_pkt = cfg_wr.data;
        spd_pkg::ADR_CFG:     next_cfg = cfg_wr.data;
        spd_pkg::ADR_STOP_LO: next_stop[7:0]    = cfg_wr.data;
        spd_pkg::ADR_STOP_HI: next_stop[15:8]   = cfg_wr.data;
        spd_pkg::ADR_RES_LO:  next_resume[7:0]  = cfg_wr.data;
        spd_pkg::ADR_RES_HI:  next_resume[15:8] = cfg_wr.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      de_delay_high         <= spd_pkg::RST_DE;
      de_delay_middle       <= spd_pkg::RST_DE;
      de_delay_low          <= spd_pkg::RST_DE;
      byte_gap_timeout      <= spd_pkg::RST_GAP;
      packet_size_limit     <= spd_pkg::RST_PKT;
      cfg_flags             <= spd_pkg::RST_CFG;
      flow_stop_threshold   <= spd_pkg::RST_STOP;
      flow_resume_threshold <= spd_pkg::RST_RESUME;
    end else begin
      de_delay_high         <= next_de_high;
      de_delay_middle       <= next_de_mid;
      de_delay_low          <= next_de_low;
      byte_gap_timeout      <= next_gap;
      packet_size_limit     <= next_pkt;
      cfg_flags             <= next_cfg;
      flow_stop_threshold   <= next_stop;
      flow_resume_threshold <= next_resume;
    end
  end

  always_comb begin
    case (cfg_rd_addr)
      spd_pkg::ADR_DE_HIGH: next_rd = de_delay_high;
      spd_pkg::ADR_DE_MID:  next_rd = de_delay_middle;
      spd_pkg::ADR_DE_LOW:  next_rd = de_delay_low;
      spd_pkg::ADR_GAP:     next_rd = byte_gap_timeout;
      spd_pkg::ADR_PKT:     next_rd = packet_size_limit;
      spd_pkg::ADR_CFG:     next_rd = cfg_flags;
      spd_pkg::ADR_STOP_LO: next_rd = flow_stop_threshold[7:0];
      spd_pkg::ADR_STOP_HI: next_rd = flow_stop_threshold[15:8];
      spd_pkg::ADR_RES_LO:  next_rd = flow_resume_threshold[7:0];
      spd_pkg::ADR_RES_HI:  next_rd = flow_resume_threshold[15:8];
      default:              next_rd = 8'h00;
    endcase
  end

  // Effective settings
  always_comb begin
    cap = rate_fast ? spd_pkg::PKT_MAX_FAST : spd_pkg::PKT_MAX_SLOW;
    // RULE_03 auto timeout
    eff_gap = cfg_flags[spd_pkg::CFG_AUTO_BIT] ? auto_gap : byte_gap_timeout;
    // RULE_06 auto size default
    if (cfg_flags[spd_pkg::CFG_AUTO_BIT]) eff_size = cap;
    // RULE_05 payload cap
    else if (packet_size_limit > cap || packet_size_limit == 8'h00) eff_size = cap;
    else eff_size = packet_size_limit;
  end

  assign accept = host_rx_valid && state == spd_pkg::SPD_COLLECT;

  // Framer and flow control
  always_comb begin
    next_state     = state;
    next_acc       = acc;
    next_units     = units;
    next_sub       = sub;
    next_cnt       = cnt;
    next_cts       = cts_hi;
    next_info      = pkt_info;
    next_pkt_valid = pkt_valid;
    // RULE_14 inbound count only
    if (accept) next_cnt = cnt + 16'h0001;
    case (state)
      spd_pkg::SPD_COLLECT: begin
        if (accept) begin
          // RULE_22 restart gap timer
          next_acc   = acc + 8'h01;
          next_units = 8'h00;
          next_sub   = 16'h0000;
          // RULE_04 size closes packet
          if (acc + 8'h01 >= eff_size) next_state = spd_pkg::SPD_READY;
        end else if (acc != 8'h00) begin
          if (sub == 16'(spd_pkg::GAP_UNIT_CYC - 1)) begin
            next_sub   = 16'h0000;
            next_units = units + 8'h01;
            // RULE_01 gap closes packet
            if (units + 8'h01 > eff_gap) next_state = spd_pkg::SPD_READY;
          end else begin
            next_sub = sub + 16'h0001;
          end
        end
      end
      spd_pkg::SPD_READY: begin
        // RULE_08 header excluded from size
        next_info.size = acc;
        next_info.slots = slots_of(rate_fast, eff_size);
        // RULE_12 first slot server-only
        next_info.server_slot_only = cfg_flags[spd_pkg::CFG_FDX_BIT];
        next_pkt_valid = 1'b1;
        next_state = spd_pkg::SPD_WAIT;
      end
      spd_pkg::SPD_WAIT: begin
        // RULE_15 hold until done
        if (pkt_done) begin
          next_pkt_valid = 1'b0;
          next_cnt   = cnt - 16'(acc);
          next_acc   = 8'h00;
          next_units = 8'h00;
          next_sub   = 16'h0000;
          next_state = spd_pkg::SPD_COLLECT;
        end
      end
      default: next_state = spd_pkg::SPD_COLLECT;
    endcase
    // RULE_16 stop host
    if (next_cnt >= flow_stop_threshold) next_cts = 1'b1;
    // RULE_17 resume host
    // RULE_23 hysteresis band
    else if (next_cnt <= flow_resume_threshold) next_cts = 1'b0;
  end

  // Outbound path
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_tv = host_tx_valid;
    next_td = host_tx_data;
    if (radio_rx_valid && (wp - rp) != 9'(spd_pkg::BUF_DEPTH)) next_wp = wp + 9'h001;
    if (host_tx_valid && host_tx_ready) next_tv = 1'b0;
    // RULE_19 send when available
    // RULE_20 hold while request high
    if ((!next_tv) && wp != rp && !(rts_mode && rts_n)) begin
      next_tv = 1'b1;
      next_td = otx[rp[spd_pkg::BUF_AW-1:0]];
      next_rp = rp + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (radio_rx_valid && (wp - rp) != 9'(spd_pkg::BUF_DEPTH))
      otx[wp[spd_pkg::BUF_AW-1:0]] <= radio_rx_data;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state              <= spd_pkg::SPD_COLLECT;
      acc                <= 8'h00;
      units              <= 8'h00;
      sub                <= 16'h0000;
      cnt                <= 16'h0000;
      cts_hi             <= 1'b0;
      pkt_valid          <= 1'b0;
      pkt_info           <= '0;
      wp                 <= '0;
      rp                 <= '0;
      host_tx_valid      <= 1'b0;
      host_tx_data       <= 8'h00;
      cfg_rd_data        <= 8'h00;
      line_driver_enable <= 1'b0;
      de_delay           <= 24'h000000;
      rx_count           <= 16'h0000;
      cts_n              <= 1'b0;
    end else begin
      state              <= next_state;
      acc                <= next_acc;
      units              <= next_units;
      sub                <= next_sub;
      cnt                <= next_cnt;
      cts_hi             <= next_cts;
      cts_n              <= next_cts;
      pkt_valid          <= next_pkt_valid;
      pkt_info           <= next_info;
      wp                 <= next_wp;
      rp                 <= next_rp;
      host_tx_valid      <= next_tv;
      host_tx_data       <= next_td;
      cfg_rd_data        <= next_rd;
      line_driver_enable <= next_tv;
      de_delay           <= {de_delay_high, de_delay_middle, de_delay_low};
      rx_count           <= next_cnt;
    end
  end

  sequence s_full_hit;
    accept && (acc + 8'h01 >= eff_size);
  endsequence

  a_size_close: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
    s_full_hit |=> state == spd_pkg::SPD_READY ##1 pkt_valid)
    else $error("size limit did not close packet");
  a_gap_timer_idle: assert property (@(posedge clk) disable iff (!arst_n) // RULE_22
    (state == spd_pkg::SPD_COLLECT && acc == 8'h00) |-> sub == 16'h0000)
    else $error("gap timer ran with empty accumulator");
  a_gap_close: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
    (state == spd_pkg::SPD_COLLECT && units > eff_gap) |-> 1'b0)
    else $error("gap exceeded without closing packet");
  a_size_cap: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
    pkt_valid |-> pkt_info.size <= (rate_fast ? 8'hEF : 8'h60))
    else $error("packet above rate cap");
  a_hold_packet: assert property (@(posedge clk) disable iff (!arst_n) // RULE_15
    (pkt_valid && !pkt_done) |=> pkt_valid && $stable(pkt_info))
    else $error("packet dropped before done");
  a_cts_stop: assert property (@(posedge clk) disable iff (!arst_n) // RULE_16
    (rx_count >= flow_stop_threshold) |-> cts_n)
    else $error("cts low above stop threshold");
  a_cts_resume: assert property (@(posedge clk) disable iff (!arst_n) // RULE_17
    (rx_count <= flow_resume_threshold && rx_count < flow_stop_threshold) |-> !cts_n)
    else $error("cts high at resume threshold");
  a_rts_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE_20
    (rts_mode && rts_n && !host_tx_valid) |=> !$rose(host_tx_valid))
    else $error("data sent while request high");
  a_slot_count: assert property (@(posedge clk) disable iff (!arst_n) // RULE_10
    $rose(pkt_valid) |-> pkt_info.slots >= 3'h2 && pkt_info.slots <= 3'h6)
    else $error("slot count out of range");
  a_gap_floor: assert property (@(posedge clk) disable iff (!arst_n) // RULE_02
    byte_gap_timeout >= spd_pkg::GAP_MIN)
    else $error("gap timeout below minimum");
  a_de_delay: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
    de_delay == $past({de_delay_high, de_delay_middle, de_delay_low}))
    else $error("delay bytes not presented");
  a_rts_free: assert property (@(posedge clk) disable iff (!arst_n) // RULE_19
    (!rts_mode && !host_tx_valid && wp != rp) |=> host_tx_valid)
    else $error("buffered byte not sent without request mode");
  a_server_slot: assert property (@(posedge clk) disable iff (!arst_n) // RULE_12
    $rose(pkt_valid) |-> pkt_info.server_slot_only == cfg_flags[spd_pkg::CFG_FDX_BIT])
    else $error("server slot flag wrong");
endmodule // spd_framer

// ---- rtl/spd_pkg.sv ----
// Functional notes
// RULE_01 - Gap between bytes above timeout closes accumulated bytes as one packet
// RULE_02 - Timeout counts 200 us units, minimum two; host covers two characters
// RULE_03 - Auto configuration replaces stored timeout with baud-based default
// RULE_04 - Reaching packet size closes the packet; first condition met wins
// RULE_05 - Payload capped at 239 bytes at 500 kbps, 96 at 280 kbps
// RULE_06 - Auto configuration flag bit 0 replaces stored size with rate default
// RULE_07 - Host should never program packet size below seven bytes
// RULE_08 - Own header bytes are not counted against packet size
// RULE_09 - 280 kbps: 4 slots to 0x09, 3 to 0x25, 2 to 0x60
// RULE_10 - 500 kbps: 6,5,4,3 slots by size bands, 2 up to 0xEF
// RULE_11 - Network configurer keeps slots per hop equal on every radio
// RULE_12 - Full duplex reserves first slot for server, rest shared by clients
// RULE_13 - Driver enable delay bytes from 8.125 MHz over 81 times baud
// RULE_14 - Host-bound and radio-bound data kept in separate buffers; only host-bound bytes are buffered here, radio-bound ones are counted
// RULE_15 - Packet held in buffer until acknowledged or attempts exhausted
// RULE_16 - Clear-to-send goes high when buffer count reaches stop threshold
// RULE_17 - Clear-to-send goes low when count falls to resume threshold
// RULE_18 - Host stops sending while clear-to-send is high
// RULE_19 - Without request-to-send mode, data goes to host when available
// RULE_20 - With request-to-send mode, hold while high, resume oldest first
// RULE_21 - Host tolerates up to two more bytes after changing request-to-send
// RULE_22 - Gap timer restarts per byte, runs only while bytes are pending
// RULE_23 - Stop threshold above resume threshold gives hysteresis
package spd_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned GAP_UNIT_NS   = 200_000;
  localparam int unsigned GAP_UNIT_CYC  = GAP_UNIT_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [7:0]  ADR_DE_HIGH   = 8'h49;
  localparam logic [7:0]  ADR_DE_MID    = 8'h4A;
  localparam logic [7:0]  ADR_DE_LOW    = 8'h4B;
  localparam logic [7:0]  ADR_GAP       = 8'h58;
  localparam logic [7:0]  ADR_PKT       = 8'h5A;
  localparam logic [7:0]  ADR_STOP_LO   = 8'h5C;
  localparam logic [7:0]  ADR_STOP_HI   = 8'h5D;
  localparam logic [7:0]  ADR_RES_LO    = 8'h5E;
  localparam logic [7:0]  ADR_RES_HI    = 8'h5F;
  localparam logic [7:0]  ADR_CFG       = 8'h56;
  localparam int unsigned CFG_AUTO_BIT  = 0;
  localparam int unsigned CFG_FDX_BIT   = 1;
  localparam logic [7:0]  GAP_MIN       = 8'h02;
  localparam logic [7:0]  PKT_MAX_FAST  = 8'hEF;
  localparam logic [7:0]  PKT_MAX_SLOW  = 8'h60;
  localparam logic [7:0]  RST_GAP       = 8'h02;
  localparam logic [7:0]  RST_PKT       = 8'h80;
  localparam logic [7:0]  RST_CFG       = 8'h00;
  localparam logic [15:0] RST_STOP      = 16'h00C0;
  localparam logic [15:0] RST_RESUME    = 16'h0040;
  localparam logic [7:0]  RST_DE        = 8'h00;
  localparam int unsigned BUF_AW        = 8;
  localparam int unsigned BUF_DEPTH     = 256;
  typedef enum logic [1:0] {
    SPD_COLLECT = 2'b00,
    SPD_READY   = 2'b01,
    SPD_WAIT    = 2'b10
  } spd_state_type;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } spd_cfg_wr_type;
  typedef struct packed {
    logic [7:0] size;
    logic [2:0] slots;
    logic       server_slot_only;
  } spd_pkt_type;
endpackage

// ---- verification/spd_host_model.sv ----
`timescale 1ns/1ps
module spd_host_model (
  // Clock
  input  wire logic       clk,
  // Device to host
  input  wire logic       cts_n,
  input  wire logic       host_tx_valid,
  input  wire logic [7:0] host_tx_data,
  output logic            host_tx_ready,
  // Host to device
  output logic            host_rx_valid,
  output logic [7:0]      host_rx_data,
  output logic            rts_n
);
  logic [7:0] got[$];
  initial begin
    host_rx_valid = 1'b0;
    host_rx_data  = 8'h5A;
    rts_n         = 1'b0;
    host_tx_ready = 1'b1;
  end
  task automatic send_byte(input logic [7:0] d, input logic raw);
    int n;
    n = 0;
    while (!raw && cts_n !== 1'b0 && n < 500) begin
      @(negedge clk);
      n++;
    end
    host_rx_valid = 1'b1;
    host_rx_data  = d;
    @(negedge clk);
    host_rx_valid = 1'b0;
    host_rx_data  = ~d;
    @(negedge clk);
  endtask
  always @(posedge clk) begin
    if (host_tx_valid && host_tx_ready) begin
      got.push_back(host_tx_data);
    end
  end
endmodule // spd_host_model

// ---- verification/spd_framer_tb.sv ----
`timescale 1ns/1ps
module spd_framer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  spd_pkg::spd_cfg_wr_type cfg_wr = '0;
  logic [7:0] cfg_rd_addr = 8'h00, auto_gap = 8'h02, radio_rx_data = 8'h00;
  logic rate_fast = 1'b0, rts_mode = 1'b0, pkt_done = 1'b0, radio_rx_valid = 1'b0;
  logic rts_n, cts_n, host_tx_valid, host_tx_ready, host_rx_valid, pkt_valid, line_driver_enable;
  logic [7:0] cfg_rd_data, host_tx_data, host_rx_data;
  spd_pkg::spd_pkt_type pkt_info;
  logic [23:0] de_delay;
  logic [15:0] rx_count;
  int failures = 0, comparisons = 0, cyc = 0;
  logic [7:0] sz [0:13] = '{8'h09, 8'h0A, 8'h25, 8'h26, 8'h60, 8'h0C, 8'h0D,
                            8'h25, 8'h26, 8'h47, 8'h48, 8'h7D, 8'h7E, 8'hEF};
  logic [2:0] sl [0:13] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h6, 3'h5,
                            3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2};
  logic [7:0] ra [0:11] = '{8'h49, 8'h4A, 8'h4B, 8'h56, 8'h58, 8'h5A,
                            8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h00, 8'h30};
  logic [7:0] rv [0:11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h80,
                            8'hC0, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};

  always #5 clk = ~clk;

  spd_framer i_dut (
    .clk(clk), .arst_n(arst_n), .cfg_wr(cfg_wr), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_data(cfg_rd_data), .rate_fast(rate_fast), .auto_gap(auto_gap),
    .rts_mode(rts_mode), .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
    .rts_n(rts_n), .cts_n(cts_n), .host_tx_valid(host_tx_valid),
    .host_tx_data(host_tx_data), .host_tx_ready(host_tx_ready), .pkt_valid(pkt_valid),
    .pkt_info(pkt_info), .pkt_done(pkt_done), .radio_rx_valid(radio_rx_valid),
    .radio_rx_data(radio_rx_data), .line_driver_enable(line_driver_enable),
    .de_delay(de_delay), .rx_count(rx_count)
  );

  spd_host_model i_host (
    .clk(clk), .cts_n(cts_n), .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
    .host_tx_ready(host_tx_ready), .host_rx_valid(host_rx_valid),
    .host_rx_data(host_rx_data), .rts_n(rts_n)
  );

  task automatic finish_test();
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, run needs about 72700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr = '{wr: 1'b1, addr: a, data: d};
    @(negedge clk);
    cfg_wr = '0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_rd_addr = a;
    @(negedge clk);
    check("cfg_rd_data", 24'(cfg_rd_data), 24'(exp));
  endtask

  task automatic wait_pkt();
    int n;
    n = 0;
    while (pkt_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic done_pkt();
    pkt_done = 1'b1;
    @(negedge clk);
    pkt_done = 1'b0;
    @(negedge clk);
    check("pkt_valid", 24'(pkt_valid), 24'h0);
    check("rx_count", 24'(rx_count), 24'h0);
  endtask

  task automatic run_pkt(input logic [7:0] size, input logic fast, input int n,
                         input logic [2:0] slots);
    rate_fast = fast;
    wr(spd_pkg::ADR_PKT, size);
    for (int i = 0; i < n; i++) i_host.send_byte(8'(i), 1'b0);
    wait_pkt();
    check("pkt_size", 24'(pkt_info.size), 24'(n));
    check("pkt_slots", 24'(pkt_info.slots), 24'(slots));
    check("rx_count", 24'(rx_count), 24'(n));
    done_pkt();
  endtask

  task automatic push(input logic [7:0] d);
    radio_rx_valid = 1'b1;
    radio_rx_data  = d;
    @(negedge clk);
    radio_rx_valid = 1'b0;
    radio_rx_data  = ~d;
    @(negedge clk);
  endtask

  initial begin
    cycles(4);
    arst_n = 1'b1;
    cycles(1);
    for (int i = 0; i < 12; i++) rd(ra[i], rv[i]);
    wr(spd_pkg::ADR_DE_MID, 8'h05);
    wr(spd_pkg::ADR_DE_LOW, 8'h12);
    check("de_delay", de_delay, 24'h000512);
    rd(spd_pkg::ADR_DE_LOW, 8'h12);
    wr(spd_pkg::ADR_GAP, 8'h01);
    rd(spd_pkg::ADR_GAP, 8'h02);
    wr(spd_pkg::ADR_STOP_LO, 8'h08);
    wr(spd_pkg::ADR_RES_LO, 8'h04);
    wr(spd_pkg::ADR_PKT, 8'h08);
    for (int i = 0; i < 7; i++) i_host.send_byte(8'(i), 1'b0);
    cycles(3);
    check("cts_n", 24'(cts_n), 24'h0);
    i_host.send_byte(8'h07, 1'b0);
    cycles(3);
    check("cts_n", 24'(cts_n), 24'h1);
    check("pkt_valid", 24'(pkt_valid), 24'h1);
    i_host.send_byte(8'hEE, 1'b1);
    cycles(2);
    check("rx_count", 24'(rx_count), 24'h8);
    done_pkt();
    cycles(2);
    check("cts_n", 24'(cts_n), 24'h0);
    wr(spd_pkg::ADR_STOP_HI, 8'h01);
    for (int i = 0; i < 14; i++) run_pkt(sz[i], i > 4, int'(sz[i]), sl[i]);
    run_pkt(8'hFF, 1'b1, 239, 3'h2);
    run_pkt(8'hFF, 1'b0, 96, 3'h2);
    i_host.rts_n = 1'b1;
    i_host.host_tx_ready = 1'b0;
    push(8'h11);
    push(8'h22);
    cycles(8);
    check("host_tx_data", 24'(host_tx_data), 24'h11);
    check("line_driver_enable", 24'(line_driver_enable), 24'h1);
    check("host_bytes", 24'(i_host.got.size()), 24'h0);
    i_host.host_tx_ready = 1'b1;
    cycles(8);
    check("host_bytes", 24'(i_host.got.size()), 24'h2);
    check("host_byte", 24'(i_host.got[1]), 24'h22);
    rts_mode = 1'b1;
    cycles(2);
    push(8'h33);
    push(8'h44);
    cycles(8);
    check("host_bytes", 24'(i_host.got.size()), 24'h2);
    check("host_tx_valid", 24'(host_tx_valid), 24'h0);
    check("line_driver_enable", 24'(line_driver_enable), 24'h0);
    i_host.rts_n = 1'b0;
    cycles(1);
    check("line_driver_enable", 24'(line_driver_enable), 24'h1);
    cycles(7);
    check("host_byte", 24'(i_host.got[2]), 24'h33);
    check("host_byte", 24'(i_host.got[3]), 24'h44);
    check("rx_count", 24'(rx_count), 24'h0);
    // stored values overridden by auto mode
    wr(spd_pkg::ADR_PKT, 8'h09);
    wr(spd_pkg::ADR_GAP, 8'h05);
    wr(spd_pkg::ADR_CFG, 8'h03);
    i_host.send_byte(8'h61, 1'b0);
    cycles(10000);
    i_host.send_byte(8'h62, 1'b0);
    cycles(59990);
    check("pkt_valid", 24'(pkt_valid), 24'h0);
    wait_pkt();
    check("pkt_valid", 24'(pkt_valid), 24'h1);
    check("pkt_size", 24'(pkt_info.size), 24'h2);
    check("pkt_slots", 24'(pkt_info.slots), 24'h2);
    check("server_slot", 24'(pkt_info.server_slot_only), 24'h1);
    done_pkt();
    finish_test();
  end
endmodule // spd_framer_tb
